// ---- rtl/ecc_pkg.sv ----
// Purpose: shared constants, state codes and check-bit function for the memory ECC guard
// Assumes: 16-bit data halves with 6 check bits each, two halves per memory word
// Notes:   memory word layout is {chk_hi, data_hi, chk_lo, data_lo}
package ecc_pkg;

  // ---------------------------------------------------------------
  // widths and layout
  // ---------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int CHK_W  = 6;
  localparam int HALVES = 2;
  localparam int HALF_W = DATA_W + CHK_W;
  localparam int WORD_W = HALVES * HALF_W;
  localparam int BUS_W  = HALVES * DATA_W;
  localparam int BE_W   = BUS_W / 8;

  // ---------------------------------------------------------------
  // codes and reset values
  // ---------------------------------------------------------------
  localparam logic [3:0]        BE_LO     = 4'h3;  // aligned lower half
  localparam logic [3:0]        BE_HI     = 4'hC;  // aligned upper half
  localparam logic [3:0]        BE_ALL    = 4'hF;  // aligned full word
  localparam logic [1:0]        WMASK_ALL = 2'h3;
  localparam logic [WORD_W-1:0] INIT_WORD = {6'h3F, 16'h0000, 6'h3F, 16'h0000};
  localparam int                DEF_DEPTH = 1024;

  // row k of the code: check bit k covers data bits set in ECC_MASK[k]
  localparam logic [CHK_W-1:0][DATA_W-1:0] ECC_MASK =
    {16'h993C, 16'h3E8A, 16'hEE60, 16'hE1D1, 16'h13C7, 16'h443F};

  typedef enum logic [7:0] {
    ST_INIT      = 8'h01,
    ST_IDLE      = 8'h02,
    ST_RD_ISSUE  = 8'h04,
    ST_RD_CHECK  = 8'h08,
    ST_RMW_ISSUE = 8'h10,
    ST_RMW_CHECK = 8'h20,
    ST_DBG_ISSUE = 8'h40,
    ST_DBG_CHECK = 8'h80
  } ctrl_state_t;

  // inverted parity of masked data, one bit per mask
  function automatic logic [CHK_W-1:0] check_of(input logic [DATA_W-1:0] d);
    logic [CHK_W-1:0] c;
    c = '0;
    for (int k = 0; k < CHK_W; k++) begin
      c[k] = ~(^(d & ECC_MASK[k]));
    end
    return c;
  endfunction

endpackage

// ---- rtl/ecc_half.sv ----
// Purpose: check, correct and encode one 16-bit half word
// Assumes: combinational only, used once per half by the controller
// Notes:   a nonzero syndrome matching no column and not one-hot is a double error
`timescale 1ns/10ps
module ecc_half (
  input  wire logic [ecc_pkg::DATA_W-1:0] rd_data,
  input  wire logic [ecc_pkg::CHK_W-1:0]  rd_check,
  input  wire logic [ecc_pkg::DATA_W-1:0] enc_data,
  output logic      [ecc_pkg::DATA_W-1:0] corr_data,
  output logic      [ecc_pkg::CHK_W-1:0]  enc_check,
  output logic                            single_err,
  output logic                            double_err
);

  logic [ecc_pkg::CHK_W-1:0] syndrome;
  logic [ecc_pkg::CHK_W-1:0] col;

  // ---------------------------------------------------------------
  // encoder for outgoing data
  // ---------------------------------------------------------------
  assign enc_check = ecc_pkg::check_of(enc_data);

  // ---------------------------------------------------------------
  // syndrome decode and single-bit correction
  // ---------------------------------------------------------------
  always_comb begin
    col        = '0;
    syndrome   = rd_check ^ ecc_pkg::check_of(rd_data);
    corr_data  = rd_data;
    single_err = 1'b0;
    double_err = 1'b0;
    if (syndrome != '0) begin
      if ($onehot(syndrome)) begin
        single_err = 1'b1;  // check bit itself flipped, data is good
      end else begin
        double_err = 1'b1;
        for (int i = 0; i < ecc_pkg::DATA_W; i++) begin
          for (int k = 0; k < ecc_pkg::CHK_W; k++) begin
            col[k] = ecc_pkg::ECC_MASK[k][i];
          end
          if (syndrome == col) begin
            corr_data[i] = ~rd_data[i];
            single_err   = 1'b1;
            double_err   = 1'b0;
          end
        end
      end
    end
  end

endmodule // ecc_half

// ---- rtl/mem_ecc_controller.sv ----
// Purpose: ECC guard between bus initiators and a static memory array
// Assumes: memory samples its command on a clock edge and returns read data
//          in the cycle after that edge; one bus request in flight at a time
// Notes:   debug path runs only when the bus side is quiet
`timescale 1ns/10ps
// Function
// - check every ordinary read and return corrected data on a single-bit error
// - on a single-bit read error write the corrected word back unless disabled
// - set the single-error flag when an ordinary access sees a single-bit error
// - mark read data invalid on a double-bit error
// - after power-up fill all memory with zero data and valid check bits
// - block accesses and hold init-done low until the fill is complete
// - interrupt only for single-bit errors and only when enabled
// - check bits 0 to 2 are inverted parities over masks 443F, 13C7, E1D1
// - check bits 3 to 5 are inverted parities over masks EE60, 3E8A, 993C
// - debug accesses have lowest priority and wait for ordinary traffic
// - a debug request during the fill waits until the fill is done
// - with repair disabled reads still correct and flag but memory stays unchanged
// - ignore new debug commands while a debug command is still active
// - debug write stores raw data and check value, then clears its command
// - debug write is a plain half-word write with no check or error report
// - debug read loads raw data and raw check value, then clears its command
// - debug read never repairs, checks or reports errors
// - both debug commands set together run only the debug write
// - aligned 2- and 4-byte writes go straight in; others become read-modify-write
// - a double-bit error in the read phase blocks the write and reports an error
module mem_ecc_controller #(
  parameter int DEPTH = ecc_pkg::DEF_DEPTH,
  localparam int ADDR_W = $clog2(DEPTH)
) (
  input  wire logic                            clk_sys,
  input  wire logic                            rst_n,
  input  wire logic                            req_valid,
  output logic                                 req_ready,
  input  wire logic                            req_write,
  input  wire logic [ADDR_W-1:0]               req_addr,
  input  wire logic [ecc_pkg::BE_W-1:0]        req_be,
  input  wire logic [ecc_pkg::BUS_W-1:0]       req_wdata,
  output logic                                 rsp_valid,
  output logic      [ecc_pkg::BUS_W-1:0]       rsp_rdata,
  output logic                                 rsp_invalid,
  output logic                                 rsp_error,
  output logic                                 mem_en,
  output logic                                 mem_we,
  output logic      [ecc_pkg::HALVES-1:0]      mem_wmask,
  output logic      [ADDR_W-1:0]               mem_addr,
  output logic      [ecc_pkg::WORD_W-1:0]      mem_wdata,
  input  wire logic [ecc_pkg::WORD_W-1:0]      mem_rdata,
  input  wire logic                            read_repair_disable,
  input  wire logic                            single_error_irq_enable,
  input  wire logic                            single_error_flag_clear,
  output logic                                 single_error_flag,
  output logic                                 single_error_irq,
  output logic                                 init_done,
  input  wire logic                            debug_write_cmd_set,
  input  wire logic                            debug_read_cmd_set,
  input  wire logic [ADDR_W:0]                 debug_address_pointer,
  input  wire logic [ecc_pkg::DATA_W-1:0]      debug_data_word,
  input  wire logic [ecc_pkg::CHK_W-1:0]       debug_check_value,
  output logic                                 debug_write_cmd,
  output logic                                 debug_read_cmd,
  output logic      [ecc_pkg::DATA_W-1:0]      debug_data_reg,
  output logic      [ecc_pkg::CHK_W-1:0]       debug_check_reg
);

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (DEPTH < 2) begin : g_bad_depth
    $error("DEPTH must be at least 2");
  end

  ecc_pkg::ctrl_state_t                             state;
  ecc_pkg::ctrl_state_t                             next_state;
  logic [ADDR_W-1:0]                                init_addr;
  logic [ecc_pkg::BE_W-1:0]                         hold_be;
  logic [ecc_pkg::BUS_W-1:0]                        hold_wdata;
  logic                                             dbg_half;
  logic [ecc_pkg::HALVES-1:0][ecc_pkg::DATA_W-1:0]  corr_data;
  logic [ecc_pkg::HALVES-1:0][ecc_pkg::DATA_W-1:0]  enc_data;
  logic [ecc_pkg::HALVES-1:0][ecc_pkg::CHK_W-1:0]   enc_check;
  logic [ecc_pkg::HALVES-1:0]                       half_sbe;
  logic [ecc_pkg::HALVES-1:0]                       half_dbe;
  logic [ecc_pkg::WORD_W-1:0]                       new_word;
  logic                                             any_sbe;
  logic                                             any_dbe;
  logic                                             take;
  logic                                             aligned_wr;
  logic                                             dbg_start;
  logic                                             init_last;
  logic                                             flag_set;
  logic                                             next_flag;

  // ---------------------------------------------------------------
  // per-half check and encode
  // ---------------------------------------------------------------
  for (genvar h = 0; h < ecc_pkg::HALVES; h++) begin : g_half
    ecc_half u_half (
      .rd_data    (mem_rdata[h*ecc_pkg::HALF_W +: ecc_pkg::DATA_W]),
      .rd_check   (mem_rdata[h*ecc_pkg::HALF_W+ecc_pkg::DATA_W +: ecc_pkg::CHK_W]),
      .enc_data   (enc_data[h]),
      .corr_data  (corr_data[h]),
      .enc_check  (enc_check[h]),
      .single_err (half_sbe[h]),
      .double_err (half_dbe[h])
    );
    assign new_word[h*ecc_pkg::HALF_W +: ecc_pkg::HALF_W] = {enc_check[h], enc_data[h]};
  end

  // data to encode depends on which write is being built
  always_comb begin
    for (int h = 0; h < ecc_pkg::HALVES; h++) begin
      for (int b = 0; b < 2; b++) begin
        if (state == ecc_pkg::ST_INIT) begin
          enc_data[h][b*8 +: 8] = 8'h00;
        end else if (state == ecc_pkg::ST_IDLE) begin
          enc_data[h][b*8 +: 8] = req_wdata[(2*h+b)*8 +: 8];
        end else if (state == ecc_pkg::ST_RMW_CHECK && hold_be[2*h+b]) begin
          enc_data[h][b*8 +: 8] = hold_wdata[(2*h+b)*8 +: 8];
        end else begin
          enc_data[h][b*8 +: 8] = corr_data[h][b*8 +: 8];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // request decode
  // ---------------------------------------------------------------
  assign any_sbe    = |half_sbe;
  assign any_dbe    = |half_dbe;
  assign take       = req_valid && req_ready;
  assign aligned_wr = req_write && (req_be inside {ecc_pkg::BE_LO, ecc_pkg::BE_HI,
                                                   ecc_pkg::BE_ALL});
  assign init_last  = (init_addr == ADDR_W'(DEPTH - 1));
  assign dbg_start  = (state == ecc_pkg::ST_IDLE) && (debug_write_cmd || debug_read_cmd)
                      && !req_valid;

  // ---------------------------------------------------------------
  // control state machine
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      ecc_pkg::ST_INIT: begin
        if (init_last) begin
          next_state = ecc_pkg::ST_IDLE;
        end
      end
      ecc_pkg::ST_IDLE: begin
        if (take && !aligned_wr) begin
          next_state = req_write ? ecc_pkg::ST_RMW_ISSUE : ecc_pkg::ST_RD_ISSUE;
        end else if (dbg_start) begin
          next_state = ecc_pkg::ST_DBG_ISSUE;
        end
      end
      ecc_pkg::ST_RD_ISSUE:  next_state = ecc_pkg::ST_RD_CHECK;
      ecc_pkg::ST_RMW_ISSUE: next_state = ecc_pkg::ST_RMW_CHECK;
      ecc_pkg::ST_RD_CHECK:  next_state = ecc_pkg::ST_IDLE;
      ecc_pkg::ST_RMW_CHECK: next_state = ecc_pkg::ST_IDLE;
      ecc_pkg::ST_DBG_ISSUE: begin
        next_state = debug_read_cmd ? ecc_pkg::ST_DBG_CHECK : ecc_pkg::ST_IDLE;
      end
      ecc_pkg::ST_DBG_CHECK: next_state = ecc_pkg::ST_IDLE;
      default:               next_state = ecc_pkg::ST_IDLE;
    endcase
  end

  // state, ready and init progress
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state     <= ecc_pkg::ST_INIT;
      req_ready <= 1'b0;
      init_addr <= '0;
      init_done <= 1'b0;
    end else begin
      state     <= next_state;
      req_ready <= (next_state == ecc_pkg::ST_IDLE) && !dbg_start;
      if (state == ecc_pkg::ST_INIT) begin
        init_addr <= init_addr + 1'b1;
        init_done <= init_last;
      end
    end
  end

  // hold the request for the read-modify-write phase
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hold_be    <= '0;
      hold_wdata <= '0;
      dbg_half   <= 1'b0;
    end else begin
      if (take) begin
        hold_be    <= req_be;
        hold_wdata <= req_wdata;
      end
      if (dbg_start) begin
        dbg_half <= debug_address_pointer[0];
      end
    end
  end

  // ---------------------------------------------------------------
  // memory command
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mem_en    <= 1'b0;
      mem_we    <= 1'b0;
      mem_wmask <= '0;
      mem_addr  <= '0;
      mem_wdata <= '0;
    end else begin
      mem_en <= 1'b0;
      mem_we <= 1'b0;
      unique case (state)
        ecc_pkg::ST_INIT: begin
          mem_en    <= 1'b1;
          mem_we    <= 1'b1;
          mem_wmask <= ecc_pkg::WMASK_ALL;
          mem_addr  <= init_addr;
          mem_wdata <= new_word;
        end
        ecc_pkg::ST_IDLE: begin
          if (take) begin
            mem_en    <= 1'b1;
            mem_we    <= aligned_wr;
            mem_wmask <= {req_be[2], req_be[0]};
            mem_addr  <= req_addr;
            mem_wdata <= new_word;
          end else if (dbg_start) begin
            mem_en    <= 1'b1;
            mem_we    <= debug_write_cmd;
            mem_wmask <= debug_address_pointer[0] ? 2'h2 : 2'h1;
            mem_addr  <= debug_address_pointer[ADDR_W:1];
            mem_wdata <= {debug_check_value, debug_data_word,
                          debug_check_value, debug_data_word};
          end
        end
        ecc_pkg::ST_RD_CHECK: begin
          if (any_sbe && !any_dbe && !read_repair_disable) begin
            mem_en    <= 1'b1;
            mem_we    <= 1'b1;
            mem_wmask <= ecc_pkg::WMASK_ALL;
            mem_wdata <= new_word;
          end
        end
        ecc_pkg::ST_RMW_CHECK: begin
          if (!any_dbe) begin
            mem_en    <= 1'b1;
            mem_we    <= 1'b1;
            mem_wmask <= ecc_pkg::WMASK_ALL;
            mem_wdata <= new_word;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // bus answer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rsp_valid   <= 1'b0;
      rsp_rdata   <= '0;
      rsp_invalid <= 1'b0;
      rsp_error   <= 1'b0;
    end else begin
      rsp_valid   <= 1'b0;
      rsp_invalid <= 1'b0;
      rsp_error   <= 1'b0;
      if (state == ecc_pkg::ST_IDLE && take && aligned_wr) begin
        rsp_valid <= 1'b1;
      end else if (state == ecc_pkg::ST_RD_CHECK) begin
        rsp_valid   <= 1'b1;
        rsp_rdata   <= {corr_data[1], corr_data[0]};
        rsp_invalid <= any_dbe;
      end else if (state == ecc_pkg::ST_RMW_CHECK) begin
        rsp_valid <= 1'b1;
        rsp_error <= any_dbe;
      end
    end
  end

  // ---------------------------------------------------------------
  // single-error flag and interrupt
  // ---------------------------------------------------------------
  assign flag_set  = any_sbe && (state == ecc_pkg::ST_RD_CHECK
                                 || state == ecc_pkg::ST_RMW_CHECK);
  assign next_flag = flag_set || (single_error_flag && !single_error_flag_clear);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      single_error_flag <= 1'b0;
      single_error_irq  <= 1'b0;
    end else begin
      single_error_flag <= next_flag;
      single_error_irq  <= next_flag && single_error_irq_enable;
    end
  end

  // ---------------------------------------------------------------
  // debug command bits and capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      debug_write_cmd <= 1'b0;
      debug_read_cmd  <= 1'b0;
      debug_data_reg  <= '0;
      debug_check_reg <= '0;
    end else begin
      if (!debug_write_cmd && !debug_read_cmd) begin
        if (debug_write_cmd_set) begin
          debug_write_cmd <= 1'b1;
        end else if (debug_read_cmd_set) begin
          debug_read_cmd <= 1'b1;
        end
      end
      if (state == ecc_pkg::ST_DBG_ISSUE && debug_write_cmd) begin
        debug_write_cmd <= 1'b0;
      end
      if (state == ecc_pkg::ST_DBG_CHECK) begin
        debug_read_cmd  <= 1'b0;
        debug_data_reg  <= mem_rdata[dbg_half*ecc_pkg::HALF_W +: ecc_pkg::DATA_W];
        debug_check_reg <= mem_rdata[dbg_half*ecc_pkg::HALF_W+ecc_pkg::DATA_W
                                     +: ecc_pkg::CHK_W];
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_read_take;
    req_valid && req_ready && !req_write;
  endsequence

  sequence s_aligned_take;
    req_valid && req_ready && aligned_wr;
  endsequence

  sequence s_dbg_read;
    state == ecc_pkg::ST_DBG_ISSUE && debug_read_cmd ##1 state == ecc_pkg::ST_DBG_CHECK;
  endsequence

  a_read_answer: assert property (s_read_take |-> ##3 rsp_valid)
    else $error("read answer not three cycles after take");
  a_aligned_write: assert property (s_aligned_take |=>
      mem_en && mem_we && rsp_valid && mem_addr == $past(req_addr))
    else $error("aligned write not issued in one cycle");
  a_repair_write: assert property (state == ecc_pkg::ST_RD_CHECK && any_sbe && !any_dbe
      && !read_repair_disable |=> mem_en && mem_we && mem_wmask == 2'h3)
    else $error("single error not repaired");
  a_repair_off: assert property (state == ecc_pkg::ST_RD_CHECK && read_repair_disable
      |=> !mem_we && rsp_valid)
    else $error("memory written with repair disabled");
  a_error_flag: assert property (flag_set |=> single_error_flag)
    else $error("single error flag not set");
  a_read_invalid: assert property (state == ecc_pkg::ST_RD_CHECK && any_dbe
      |=> rsp_valid && rsp_invalid)
    else $error("double error read not marked invalid");
  a_rmw_blocked: assert property (state == ecc_pkg::ST_RMW_CHECK && any_dbe
      |=> rsp_error && !mem_en)
    else $error("read-modify-write not blocked on double error");
  a_init_fill: assert property (!init_done && mem_en
      |-> mem_we && mem_wdata == ecc_pkg::INIT_WORD && !req_ready)
    else $error("fill write wrong or access open during fill");
  a_init_gate: assert property (!init_done |-> state != ecc_pkg::ST_DBG_ISSUE
      && !rsp_valid)
    else $error("access during fill");
  a_irq_follow: assert property (single_error_irq
      == (single_error_flag && $past(single_error_irq_enable)))
    else $error("irq does not follow flag and enable");
  a_dbg_both: assert property (!debug_write_cmd && !debug_read_cmd && debug_write_cmd_set
      && debug_read_cmd_set |=> debug_write_cmd && !debug_read_cmd)
    else $error("both debug commands not resolved to write");
  a_dbg_busy: assert property ((debug_write_cmd || debug_read_cmd)
      |=> !$rose(debug_write_cmd) && !$rose(debug_read_cmd))
    else $error("debug command accepted while busy");
  a_dbg_order: assert property (state == ecc_pkg::ST_DBG_ISSUE
      |-> $past(state) == ecc_pkg::ST_IDLE && !$past(req_valid))
    else $error("debug access started ahead of bus traffic");
  a_dbg_write_raw: assert property (state == ecc_pkg::ST_DBG_ISSUE && debug_write_cmd
      |-> mem_we && mem_wdata[15:0] == $past(debug_data_word) ##1 !debug_write_cmd)
    else $error("debug write not raw or not completed");
  a_dbg_read_done: assert property (s_dbg_read |=> !debug_read_cmd && !mem_en
      && !rsp_valid)
    else $error("debug read not completed cleanly");

endmodule // mem_ecc_controller

// ---- dv/mem_model.sv ----
// Purpose: memory array behind the ECC guard
// Assumes: read data is valid in the cycle after the sampling edge
// Notes:   outside reads rdata shows the inverse of its last value
`timescale 1ns/10ps
module mem_model #(
  parameter int DEPTH = 8,
  localparam int AW = $clog2(DEPTH)
) (
  input  wire logic                       clk_sys,
  input  wire logic                       en,
  input  wire logic                       we,
  input  wire logic [1:0]                 wmask,
  input  wire logic [AW-1:0]              addr,
  input  wire logic [ecc_pkg::WORD_W-1:0] wdata,
  output logic      [ecc_pkg::WORD_W-1:0] rdata
);
  logic [ecc_pkg::WORD_W-1:0] ram [DEPTH];
  // -------------------------------------------------
  // half-word writes and registered reads
  // -------------------------------------------------
  always @(posedge clk_sys) begin
    if (en && we && wmask[0]) ram[addr][21:0] <= wdata[21:0];
    if (en && we && wmask[1]) ram[addr][43:22] <= wdata[43:22];
    if (en && !we) rdata <= ram[addr];
    else rdata <= ~rdata;  // stale data toggles each cycle, so it looks valid again every other cycle
  end
endmodule // mem_model

// ---- dv/tb_top.sv ----
// Purpose: self-checking bench for the memory ECC guard
// Assumes: DEPTH 8 for a short fill
// Notes:   driver queues expected answers, a monitor compares them
`timescale 1ns/10ps
module tb_top;
  logic clk_sys, rst_n, rv, rw, rrd, rse, rfc, dws, drs, rdy, sv, si, se, men, mwe, flg, irq, idn;
  logic dwc, drc;
  logic [1:0] mwm;
  logic [2:0] ra, mad;
  logic [3:0] rb, dp;
  logic [31:0] wd, sd, dv [4], seed = 32'h000115F0;
  logic [43:0] mwd, mrd;
  logic [15:0] dd, ddr;
  logic [5:0] dc, dcr;
  logic [34:0] q [$], e;
  int err_total, cmp_count;
  mem_ecc_controller #(.DEPTH(8)) dut (.clk_sys, .rst_n, .req_valid(rv), .req_ready(rdy),
    .req_write(rw), .req_addr(ra), .req_be(rb), .req_wdata(wd), .rsp_valid(sv), .rsp_rdata(sd),
    .rsp_invalid(si), .rsp_error(se), .mem_en(men), .mem_we(mwe), .mem_wmask(mwm),
    .mem_addr(mad), .mem_wdata(mwd), .mem_rdata(mrd), .read_repair_disable(rrd),
    .single_error_irq_enable(rse), .single_error_flag_clear(rfc), .single_error_flag(flg),
    .single_error_irq(irq), .init_done(idn), .debug_write_cmd_set(dws),
    .debug_read_cmd_set(drs), .debug_address_pointer(dp), .debug_data_word(dd),
    .debug_check_value(dc), .debug_write_cmd(dwc), .debug_read_cmd(drc),
    .debug_data_reg(ddr), .debug_check_reg(dcr));
  mem_model #(.DEPTH(8)) mem (.clk_sys, .en(men), .we(mwe), .wmask(mwm), .addr(mad),
    .wdata(mwd), .rdata(mrd));
  // -------------------------------------------------
  // helpers
  // -------------------------------------------------
  function automatic logic [5:0] ck(input logic [15:0] d);
    logic [15:0] m [6] = '{16'h443F, 16'h13C7, 16'hE1D1, 16'hEE60, 16'h3E8A, 16'h993C};
    for (int k = 0; k < 6; k++) ck[k] = ~(^(d & m[k]));
  endfunction
  function automatic logic [21:0] hw(input logic [15:0] d);
    return {ck(d), d};
  endfunction
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input logic ok);
    cmp_count++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("BAD %0t value mismatch", $time);
    end
  endtask
  task report_and_stop();
    if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // bus request held until taken; e = {read, invalid, error, data}
  task bus(input logic w, input logic [2:0] a, input logic [3:0] b, input logic [31:0] d,
           input logic [34:0] x);
    @(negedge clk_sys); rv = 1; rw = w; ra = a; rb = b; wd = d;
    for (int i = 0; i < 20 && rdy !== 1'b1; i++) @(negedge clk_sys);
    q.push_back(x); @(negedge clk_sys); rv = 0;
  endtask
  task dbg(input logic w, r, input logic [3:0] p, input logic [15:0] d, input logic [5:0] c);
    @(negedge clk_sys); dws = w; drs = r; dp = p; dd = d; dc = c;
    @(negedge clk_sys); dws = r; drs = w;
    @(negedge clk_sys); dws = 0; drs = 0;
    for (int i = 0; i < 30 && (dwc | drc) !== 1'b0; i++) @(negedge clk_sys);
    repeat (2) @(negedge clk_sys);
  endtask
  // -------------------------------------------------
  // clock, monitor, watchdog
  // -------------------------------------------------
  initial begin clk_sys = 0; forever #4 clk_sys = ~clk_sys; end
  always @(negedge clk_sys) if (sv === 1'b1) begin
    e = q.pop_front();
    chk({si, se} === e[33:32] && (!e[34] || sd === e[31:0]));
  end
  initial begin #20000; err_total++; report_and_stop(); end
  // -------------------------------------------------
  // main sequence
  // -------------------------------------------------
  initial begin
    {rv, rw, rrd, rse, rfc, dws, drs, ra, rb, dp, dd, dc, wd} = '0; rst_n = 0;
    repeat (2) @(negedge clk_sys); rst_n = 1;
    repeat (4) @(negedge clk_sys); chk(idn === 1'b0 && rdy === 1'b0);
    dbg(0, 1, 4'h2, 0, 0);
    chk(idn === 1'b1 && ddr === 16'h0 && dcr === 6'h3F);
    for (int i = 0; i < 8; i++) chk(mem.ram[i] === {hw(0), hw(0)});
    for (int i = 0; i < 4; i++) begin dv[i] = xs(); bus(1, i[2:0], 4'hF, dv[i], 0); end
    repeat (2) @(negedge clk_sys);
    for (int i = 0; i < 4; i++)
      chk(mem.ram[i] === {hw(dv[i][31:16]), hw(dv[i][15:0])});
    dbg(1, 0, 4'h2, dv[1][15:0] ^ 16'h0004, ck(dv[1][15:0]));
    chk(mem.ram[1][21:0] === {ck(dv[1][15:0]), dv[1][15:0] ^ 16'h0004}
        && flg === 1'b0);
    bus(0, 1, 0, 0, {3'b100, dv[1]}); repeat (4) @(negedge clk_sys);
    chk(flg === 1'b1 && irq === 1'b0
        && mem.ram[1] === {hw(dv[1][31:16]), hw(dv[1][15:0])});
    rse = 1; repeat (2) @(negedge clk_sys); chk(irq === 1'b1);
    rfc = 1; @(negedge clk_sys); rfc = 0; repeat (2) @(negedge clk_sys);
    chk(flg === 1'b0 && irq === 1'b0);
    rrd = 1; dbg(1, 0, 4'h5, dv[2][31:16] ^ 16'h8000, ck(dv[2][31:16]));
    bus(0, 2, 0, 0, {3'b100, dv[2]}); repeat (4) @(negedge clk_sys);
    chk(flg === 1'b1 && mem.ram[2][37:22] === (dv[2][31:16] ^ 16'h8000));
    rfc = 1; @(negedge clk_sys); rfc = 0; rrd = 0;
    dbg(0, 1, 4'h5, 0, 0);
    chk(ddr === (dv[2][31:16] ^ 16'h8000) && dcr === ck(dv[2][31:16]) && flg === 1'b0
        && mem.ram[2][37:22] === ddr);
    dbg(1, 0, 4'h6, dv[3][15:0] ^ 16'h0003, ck(dv[3][15:0]));
    bus(0, 3, 0, 0, {3'b010, 32'h0});
    bus(1, 3, 4'h1, xs(), {3'b001, 32'h0}); repeat (4) @(negedge clk_sys);
    chk(flg === 1'b0 && irq === 1'b0
        && mem.ram[3][15:0] === (dv[3][15:0] ^ 16'h0003));
    dbg(1, 1, 4'h6, dv[3][15:0], ck(dv[3][15:0]));
    chk(mem.ram[3] === {hw(dv[3][31:16]), hw(dv[3][15:0])}
        && ddr === (dv[2][31:16] ^ 16'h8000));
    dbg(1, 0, 4'h1, dv[0][31:16] ^ 16'h0100, ck(dv[0][31:16]));
    bus(1, 0, 4'h2, xs(), 0); repeat (4) @(negedge clk_sys);
    chk(mem.ram[0] === {hw(dv[0][31:16]), hw({wd[15:8], dv[0][7:0]})}
        && flg === 1'b1);
    chk(q.size() == 0);
    report_and_stop();
  end
endmodule // tb_top
